// ===== rtl/tiv_pkg.sv
// Purpose: shared constants for the trap and interrupt vectoring block
// Assumes: 32-bit AXI4-Lite register bus, one aclk domain
// Notes: offsets are byte addresses of aligned 32-bit words
package tiv_pkg;
    // sizes
    localparam int TIV_TRAPS = 9;         // hardware trap sources
    localparam int TIV_NODES = 19;        // interrupt nodes handled here
    localparam int TIV_CLASS_A = 4;       // class a trap sources
    localparam int TIV_SEG_W = 8;         // vector segment width
    localparam int TIV_NUM_W = 7;         // trap number width
    // register offsets
    localparam logic [7:0] TIV_REG_SEG = 8'h00;
    localparam logic [7:0] TIV_REG_CFG = 8'h04;
    localparam logic [7:0] TIV_REG_FLAG = 8'h08;
    localparam logic [7:0] TIV_REG_TYPE = 8'h0C;
    localparam logic [7:0] TIV_REG_EN = 8'h10;
    localparam logic [7:0] TIV_REG_STAT = 8'h14;
    localparam logic [7:0] TIV_REG_PEND = 8'h18;
    // flag bit positions in the trap flag register
    localparam int TIV_FB_SR0 = 0;
    localparam int TIV_FB_STO = 1;
    localparam int TIV_FB_STU = 2;
    localparam int TIV_FB_SBRK = 3;
    localparam int TIV_FB_SR1 = 4;
    localparam int TIV_FB_UNDEFINED_OPCODE_FLAG = 5;
    localparam int TIV_FB_MEMORY_ACCESS_ERROR_FLAG = 6;
    localparam int TIV_FB_PROTECTED_INSTRUCTION_FAULT_FLAG = 7;
    localparam int TIV_FB_ILLEGAL_WORD_OPERAND_FLAG = 8;
    // trap numbers
    localparam logic [6:0] TIV_TN_SR0 = 7'h02;
    localparam logic [6:0] TIV_TN_SBRK = 7'h08;
    localparam logic [6:0] TIV_TN_CLASS_B = 7'h0A;
    localparam logic [6:0] TIV_TN_NODE0 = 7'h10;
    // spacing: bytes = 1 << (base shift + field)
    localparam logic [2:0] TIV_SHIFT_BASE = 3'h2;
    localparam logic [1:0] TIV_VECTOR_SPACING_FIELD_RST = 2'h0;
    localparam logic [7:0] TIV_SEG_RST = 8'h00;
    // bus answers
    localparam logic [1:0] TIV_RESP_OKAY = 2'h0;
    localparam logic [1:0] TIV_RESP_SLVERR = 2'h2;
    // offer state
    typedef enum logic {TIV_ST_IDLE, TIV_ST_OFFER} tiv_state_t;
endpackage

// ===== rtl/tiv_prio_enc.sv
// Purpose: lowest-index-first priority encoder
// Assumes: combinational, used inside the vectoring block
// Notes: index is zero when no request is present
`timescale 1ns/1ps
`default_nettype none
module tiv_prio_enc #(
    parameter int WIDTH = 4,
    parameter int IDX_W = 2
) (
    input wire logic [WIDTH-1:0] req,
    output logic any,
    output logic [IDX_W-1:0] idx
);
    // scan from the top so the lowest set bit wins
    always_comb begin
        any = |req;
        idx = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = IDX_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/tiv_vectoring.sv
// Purpose: hardware trap and interrupt node vectoring with AXI4-Lite regs
// Assumes: all request inputs are one-cycle pulses on aclk
// Notes: one branch offer is held until the sequencer acknowledges it
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tiv_vectoring
    import tiv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // trap conditions, bit order as the flag register
    input wire logic [TIV_TRAPS-1:0] trap_req,
    // peripheral request sources
    input wire logic [15:0] capture_compare_unit_req,
    input wire logic [3:0] external_request_unit_req,
    input wire logic [1:0] serial_unit_zero_req,
    input wire logic [1:0] serial_unit_one_req,
    input wire logic [1:0] serial_unit_two_req,
    input wire logic [2:0] general_timer_block_req,
    // program sequencer side
    output logic branch_valid,
    output logic [23:0] branch_addr,
    output logic [TIV_NUM_W-1:0] branch_num,
    output logic branch_is_trap,
    output logic branch_is_pet,
    input wire logic branch_ack,
    input wire logic trap_return
);
    // registers
    logic [TIV_SEG_W-1:0] vector_segment_register; // vector table segment
    logic [1:0] vector_spacing_field;     // in processor_config_register
    logic [TIV_TRAPS-1:0] trap_flag_register;   // sticky trap flags
    logic [TIV_NODES-1:0] node_pet_sel;   // 1: node serves a transfer
    logic [TIV_NODES-1:0] node_enable;    // node may request at all
    // service state
    logic [TIV_CLASS_A-1:0] a_pend;       // class a waiting to branch
    logic b_pend;                         // some class b waiting
    logic [TIV_NODES-1:0] node_pend;      // node requests waiting
    logic a_active;                       // class a service running
    logic b_active;                       // class b service running
    tiv_state_t state;
    logic offer_a;                        // current offer is class a
    logic offer_b;                        // current offer is class b
    logic [4:0] offer_node;               // node of current offer
    // bus holding
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // register select, used by read and write paths
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        case (a)
            TIV_REG_SEG: reg_sel = 4'h1;
            TIV_REG_CFG: reg_sel = 4'h2;
            TIV_REG_FLAG: reg_sel = 4'h3;
            TIV_REG_TYPE: reg_sel = 4'h4;
            TIV_REG_EN: reg_sel = 4'h5;
            TIV_REG_STAT: reg_sel = 4'h6;
            TIV_REG_PEND: reg_sel = 4'h7;
            default: reg_sel = 4'h0;
        endcase
    endfunction

    // byte strobes widened to a bit mask
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                         {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire [3:0] wsel = reg_sel(aw_addr);
    wire [3:0] rsel = reg_sel(s_axi_araddr);
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [31:0] wd = w_data & wmask;

    // node request assembly: shared sources or onto the capture nodes
    wire [TIV_NODES-1:0] node_src;
    assign node_src[3:0] = capture_compare_unit_req[3:0]
                           | external_request_unit_req;
    assign node_src[5:4] = capture_compare_unit_req[5:4]
                           | serial_unit_zero_req;
    assign node_src[7:6] = capture_compare_unit_req[7:6]
                           | serial_unit_one_req;
    assign node_src[11:8] = capture_compare_unit_req[11:8]
                            | external_request_unit_req;
    assign node_src[13:12] = capture_compare_unit_req[13:12]
                             | serial_unit_two_req;
    assign node_src[15:14] = capture_compare_unit_req[15:14];
    assign node_src[18:16] = general_timer_block_req;

    // candidate selection
    wire a_any;
    wire [1:0] a_idx;
    wire n_any;
    wire [4:0] n_idx;
    tiv_prio_enc #(.WIDTH(TIV_CLASS_A), .IDX_W(2)) u_enc_a (
        .req(a_pend),
        .any(a_any),
        .idx(a_idx)
    );
    tiv_prio_enc #(.WIDTH(TIV_NODES), .IDX_W(5)) u_enc_n (
        .req(node_pend & node_enable),
        .any(n_any),
        .idx(n_idx)
    );
    // class a preempts anything but class a service
    wire pick_a = a_any && !a_active;
    // class b waits while any trap service runs
    wire pick_b = !pick_a && b_pend && !a_active && !b_active;
    // nodes only outside trap service
    wire pick_n = !pick_a && !b_pend && n_any
                  && !a_active && !b_active;
    wire [TIV_NUM_W-1:0] num_a = TIV_TN_SR0
                                 + {4'h0, a_idx, 1'b0};
    wire [TIV_NUM_W-1:0] num_n = TIV_TN_NODE0
                                 + {2'h0, n_idx};
    wire [TIV_NUM_W-1:0] next_num = pick_a ? num_a :
                                    pick_b ? TIV_TN_CLASS_B :
                                    num_n;
    // offset is number times spacing
    wire [2:0] shamt = TIV_SHIFT_BASE + {1'b0, vector_spacing_field};
    wire [15:0] next_ofs = {9'h000, next_num} << shamt;
    wire start = (state == TIV_ST_IDLE) && (pick_a || pick_b || pick_n);
    wire taken = branch_valid && branch_ack;
    // pending clears at the take, decoded per source
    wire [TIV_CLASS_A-1:0] a_clr = (taken && offer_a)
                                   ? TIV_CLASS_A'(1) << offer_node : '0;
    wire [TIV_NODES-1:0] n_clr = (taken && !offer_a && !offer_b)
                                 ? TIV_NODES'(1) << offer_node : '0;
    wire flag_wr = do_write && (wsel == 4'h3);

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_have <= 1'b0;
        end
    end

    // ready flags reopen once the response is accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) s_axi_awready <= 1'b0;
            else if (s_axi_bvalid && s_axi_bready) s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready) s_axi_wready <= 1'b0;
            else if (s_axi_bvalid && s_axi_bready) s_axi_wready <= 1'b1;
        end
    end

    // write response, error for unmapped or read-only words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TIV_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 4'h0 || wsel > 4'h5)
                           ? TIV_RESP_SLVERR : TIV_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_segment_register <= TIV_SEG_RST;
            vector_spacing_field <= TIV_VECTOR_SPACING_FIELD_RST;
            node_pet_sel <= '0;
            node_enable <= '0;
        end else if (do_write) begin
            if (wsel == 4'h1) begin
                vector_segment_register <=
                    (vector_segment_register & ~wmask[7:0])
                    | wd[7:0];
            end
            if (wsel == 4'h2) begin
                vector_spacing_field <=
                    (vector_spacing_field & ~wmask[1:0])
                    | wd[1:0];
            end
            if (wsel == 4'h4) begin
                node_pet_sel <= (node_pet_sel & ~wmask[18:0])
                                | wd[18:0];
            end
            if (wsel == 4'h5) begin
                node_enable <= (node_enable & ~wmask[18:0]) | wd[18:0];
            end
        end
    end

    // trap flags: write one to clear, a new trap wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_flag_register <= '0;
        end else begin
            trap_flag_register <= (trap_flag_register
                & ~(flag_wr ? wd[TIV_TRAPS-1:0] : '0))
                | trap_req;
        end
    end

    // pending requests: a new event wins over the take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_pend <= '0;
            b_pend <= 1'b0;
            node_pend <= '0;
        end else begin
            a_pend <= (a_pend & ~a_clr)
                      | trap_req[TIV_FB_SBRK:TIV_FB_SR0];
            b_pend <= (b_pend && !(taken && offer_b))
                      || (|trap_req[TIV_FB_ILLEGAL_WORD_OPERAND_FLAG:TIV_FB_SR1]);
            node_pend <= (node_pend & ~n_clr) | node_src;
        end
    end

    // trap service levels; return ends the innermost level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_active <= 1'b0;
            b_active <= 1'b0;
        end else begin
            if (taken && offer_a) a_active <= 1'b1;
            else if (trap_return && a_active) a_active <= 1'b0;
            if (taken && offer_b) b_active <= 1'b1;
            else if (trap_return && !a_active) b_active <= 1'b0;
        end
    end

    // branch offer, held stable until acknowledged
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= TIV_ST_IDLE;
            branch_valid <= 1'b0;
            branch_addr <= 24'h00_0000;
            branch_num <= '0;
            branch_is_trap <= 1'b0;
            branch_is_pet <= 1'b0;
            offer_a <= 1'b0;
            offer_b <= 1'b0;
            offer_node <= 5'h00;
        end else begin
            case (state)
                TIV_ST_IDLE: begin
                    if (start) begin
                        state <= TIV_ST_OFFER;
                        branch_valid <= 1'b1;
                        // segment on top of number-scaled offset
                        branch_addr <= {vector_segment_register,
                                        next_ofs};
                        branch_num <= next_num;
                        branch_is_trap <= pick_a || pick_b;
                        branch_is_pet <= pick_n
                                         && node_pet_sel[n_idx];
                        offer_a <= pick_a;
                        offer_b <= pick_b;
                        offer_node <= pick_a ? {3'h0, a_idx} : n_idx;
                    end
                end
                TIV_ST_OFFER: begin
                    if (branch_ack) begin
                        state <= TIV_ST_IDLE;
                        branch_valid <= 1'b0;
                    end
                end
                default: begin
                    state <= TIV_ST_IDLE;
                    branch_valid <= 1'b0;
                end
            endcase
        end
    end

    // read data mux
    wire [31:0] stat_word = {24'h00_0000, b_pend, a_pend,
                             branch_valid, b_active, a_active};
    wire [31:0] rmux = (rsel == 4'h1) ? {24'h0, vector_segment_register} :
                       (rsel == 4'h2) ? {30'h0, vector_spacing_field} :
                       (rsel == 4'h3) ? {23'h0, trap_flag_register} :
                       (rsel == 4'h4) ? {13'h0, node_pet_sel} :
                       (rsel == 4'h5) ? {13'h0, node_enable} :
                       (rsel == 4'h6) ? stat_word :
                       (rsel == 4'h7) ? {13'h0, node_pend} : 32'h0;

    // read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TIV_RESP_OKAY;
        end else if (do_read) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= (rsel == 4'h0)
                           ? TIV_RESP_SLVERR : TIV_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence class_a_seen;
        (state == TIV_ST_IDLE) && (a_pend != '0) && !a_active;
    endsequence
    sequence class_b_taken;
        taken && offer_b;
    endsequence

    trap_branch_a: assert property (
        class_a_seen |=> branch_valid && branch_is_trap
            && branch_num >= TIV_TN_SR0 && branch_num <= TIV_TN_SBRK)
        else $error("class a trap not offered next cycle");
    trap_flag_a: assert property (
        (trap_req != '0) |=>
            ((trap_flag_register & $past(trap_req)) == $past(trap_req)))
        else $error("trap flag not set");
    trap_wait_a: assert property (
        (state == TIV_ST_IDLE) && a_active |=> !branch_valid)
        else $error("trap offered during higher trap service");
    int_block_a: assert property (
        branch_valid && !branch_is_trap |-> !a_active && !b_active)
        else $error("node offered during trap service");
    class_a_num_a: assert property (
        branch_valid && offer_a |-> branch_num[0] == 1'b0
            && branch_num == TIV_TN_SR0 + {offer_node[1:0], 1'b0})
        else $error("class a trap number wrong");
    class_b_vec_a: assert property (
        class_b_taken |-> branch_num == TIV_TN_CLASS_B ##1 b_active)
        else $error("class b vector or service wrong");
    vec_segment_a: assert property (
        $rose(branch_valid) |->
            branch_addr[23:16] == $past(vector_segment_register))
        else $error("vector segment mismatch");
    vec_offset_a: assert property (
        $rose(branch_valid) |-> branch_addr[15:0]
            == ({9'h000, branch_num} << (TIV_SHIFT_BASE
                + {1'b0, $past(vector_spacing_field)})))
        else $error("vector offset not number times spacing");
    node_num_a: assert property (
        branch_valid && !branch_is_trap |->
            branch_num == TIV_TN_NODE0 + {2'h0, offer_node})
        else $error("node trap number wrong");
    shared_ext_a: assert property (
        external_request_unit_req[0] && (state == TIV_ST_IDLE)
            |=> node_pend[0] && node_pend[8])
        else $error("external request not shared");
    shared_ser_a: assert property (
        serial_unit_zero_req[0] && (state == TIV_ST_IDLE)
            |=> node_pend[4])
        else $error("serial request not shared");
endmodule
`default_nettype wire

// ===== sim/tiv_seq_model.sv
// Purpose: program sequencer model that takes branch offers
// Assumes: offers follow the valid/ack handshake on aclk
// Notes: ack_delay cycles pass before each acknowledge
`timescale 1ns/1ps
`default_nettype none
module tiv_seq_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic branch_valid,
    input wire logic [3:0] ack_delay,
    output logic branch_ack
);
    int wait_cnt; // cycles the current offer has waited
    // acknowledge for one cycle once the delay has run out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            branch_ack <= 1'b0;
            wait_cnt <= 0;
        end else if (branch_valid && !branch_ack) begin
            if (wait_cnt >= int'(ack_delay)) begin
                branch_ack <= 1'b1;
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end else begin
            branch_ack <= 1'b0; // offer taken or absent
        end
    end
endmodule
`default_nettype wire

// ===== sim/trap_and_interrupt_vectoring_bench.sv
// Purpose: self-checking bench for the vectoring block
// Assumes: sequencer model answers offers, bench drives all sources
// Notes: expected branches are queued in order and matched at each ack
`timescale 1ns/1ps
`default_nettype none
module trap_and_interrupt_vectoring_bench import tiv_pkg::*;;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, branch_valid;
    logic branch_is_trap, branch_is_pet, branch_ack, trap_return;
    logic [7:0] s_axi_awaddr, s_axi_araddr, m_seg;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, external_request_unit_req, ack_delay;
    logic [1:0] s_axi_bresp, s_axi_rresp, m_sc, serial_unit_zero_req;
    logic [1:0] serial_unit_one_req, serial_unit_two_req;
    logic [TIV_TRAPS-1:0] trap_req;
    logic [15:0] capture_compare_unit_req;
    logic [2:0] general_timer_block_req;
    logic [23:0] branch_addr;
    logic [TIV_NUM_W-1:0] branch_num;
    logic [38:0] src; // return, traps, timers, serial 2/1/0, ext, capture
    logic [32:0] exp_q[$]; // number, trap, transfer, segment, offset
    logic [32:0] got_br; // observed branch in the same layout
    logic [18:0] m_pet; // node transfer select
    int bad_count, compares, i, s, st, n;
    assign {trap_return, trap_req, general_timer_block_req,
        serial_unit_two_req, serial_unit_one_req, serial_unit_zero_req,
        external_request_unit_req, capture_compare_unit_req} = src;
    assign got_br = {branch_num, branch_is_trap, branch_is_pet, branch_addr};
    tiv_vectoring dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trap_req,
        .capture_compare_unit_req, .external_request_unit_req,
        .serial_unit_zero_req, .serial_unit_one_req, .serial_unit_two_req,
        .general_timer_block_req, .branch_valid, .branch_addr, .branch_num,
        .branch_is_trap, .branch_is_pet, .branch_ack, .trap_return);
    tiv_seq_model seq (.aclk, .aresetn, .branch_valid, .ack_delay,
        .branch_ack);
    // free-running 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    // one clock with a bound on the total wait
    task automatic tick(inout int cnt);
        @(posedge aclk);
        cnt++;
        if (cnt > 300) begin
            bad_count++;
            $display("unexpected at %0t: wait ran out", $time);
            tally_and_finish();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int c;
        c = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(c);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er, "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int c;
        c = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            tick(c);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check({s_axi_rresp, s_axi_rdata}, {er, ed}, "read answer");
    endtask
    // one-cycle pulse on the chosen source lines
    task automatic pulse(input logic [38:0] v);
        @(posedge aclk);
        src <= v;
        @(posedge aclk);
        src <= '0;
    endtask
    // queue a branch: offset is number times spacing in the segment
    task automatic push(input int num);
        logic [15:0] off;
        off = 16'(num * (4 << m_sc));
        exp_q.push_back({7'(num), num < 16,
            num >= 16 ? m_pet[5'(num - 16)] : 1'b0, m_seg, off});
    endtask
    task automatic set_vec();
        m_seg = 8'($urandom);
        m_sc = 2'($urandom);
        ack_delay <= 4'($urandom % 4);
        axi_wr(TIV_REG_SEG, {24'h0, m_seg}, TIV_RESP_OKAY);
        axi_wr(TIV_REG_CFG, {30'h0, m_sc}, TIV_RESP_OKAY);
    endtask
    task automatic drain();
        int c;
        c = 0;
        while (exp_q.size() != 0 || branch_valid !== 1'b0) tick(c);
    endtask
    // match every accepted offer against the queued expectation
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && branch_valid === 1'b1
            && branch_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(1, 0, "branch not requested");
            end else begin
                check(got_br, exp_q.pop_front(),
                    "branch target");
            end
        end
    end
    initial begin
        src = '0;
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        ack_delay = 4'h0;
        m_pet = 19'h0;
        void'($urandom(32'hB4F546A9));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(TIV_REG_SEG, 32'h0, TIV_RESP_OKAY);
        axi_rd(TIV_REG_CFG, 32'h0, TIV_RESP_OKAY);
        axi_rd(8'h40, 32'h0, TIV_RESP_SLVERR);
        axi_wr(TIV_REG_STAT, 32'h1, TIV_RESP_SLVERR);
        // each trap alone, with its own flag
        for (i = 0; i < TIV_TRAPS; i++) begin
            set_vec();
            pulse(39'h1 << (29 + i));
            push(i < TIV_CLASS_A ? 2 + 2 * i : 10);
            drain();
            pulse(39'h1 << 38);
            axi_rd(TIV_REG_FLAG, 32'h1 << i, TIV_RESP_OKAY);
            axi_wr(TIV_REG_FLAG, 32'h1 << i, TIV_RESP_OKAY);
        end
        axi_rd(TIV_REG_FLAG, 32'h0, TIV_RESP_OKAY);
        m_pet = 19'($urandom);
        axi_wr(TIV_REG_TYPE, {13'h0, m_pet}, TIV_RESP_OKAY);
        axi_wr(TIV_REG_EN, 32'h7FFFF, TIV_RESP_OKAY);
        // every node source, external requests reaching two nodes
        for (s = 0; s < 29; s++) begin
            set_vec();
            pulse(39'h1 << s);
            if (s < 16) push(16 + s);
            else if (s < 20) begin
                push(s);
                push(s + 8);
            end else if (s < 24) push(s);
            else if (s < 26) push(s + 4);
            else push(s + 6);
            drain();
        end
        // traps and a node arriving during class a service
        pulse(39'h1 << 30);
        push(4);
        drain();
        pulse((39'h1 << 29) | (39'h1 << 34) | 39'h1);
        push(2);
        push(10);
        push(16);
        // status: class a active, class a 0 and class b waiting
        axi_rd(TIV_REG_STAT, 32'h89, TIV_RESP_OKAY);
        axi_rd(TIV_REG_PEND, 32'h1, TIV_RESP_OKAY);
        for (st = 0; st < 3; st++) begin
            repeat (8) @(posedge aclk);
            check(exp_q.size(), 3 - st, "offer during service");
            pulse(39'h1 << 38);
            n = 0;
            while (exp_q.size() > 2 - st) tick(n);
        end
        drain();
        axi_wr(TIV_REG_FLAG, 32'h1FF, TIV_RESP_OKAY);
        tally_and_finish();
    end
endmodule
`default_nettype wire
